// ===== core/eis_defs.vh
// constants of the external interrupt steering stage
`ifndef EIS_DEFS_VH
`define EIS_DEFS_VH

// ----------------------------------------------------------------------------
// widths and counts
// ----------------------------------------------------------------------------
`define EIS_N_EXT        8
`define EIS_N_LOW        4
`define EIS_SRC_W        4
`define EIS_SYNC_STAGES  2

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
// steering bit 0 = core delivery, 1 = pci output
`define EIS_STEER_RST    4'h0
`define EIS_STEER_CORE   1'b0
`define EIS_STEER_PCI    1'b1
`define EIS_XINT_IDLE    8'hff
`define EIS_PEND_RST     4'h0

// ----------------------------------------------------------------------------
// source codes reported to the core
// ----------------------------------------------------------------------------
`define EIS_SRC_NONE     4'h0
`define EIS_SRC_NMI      4'hf
// external line i reports dedicated level i plus this base
`define EIS_SRC_EXT_BASE 4'h1

`endif

// ===== core/eis_sync.v
// multi-bit two flip-flop synchroniser for asynchronous pins
`timescale 1ns/1ps

module eis_sync #(
  parameter W         = 1,
  parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
  clk,
  rst_b,
  async_in,
  sync_out
);
  input  wire         clk;
  input  wire         rst_b;
  input  wire [W-1:0] async_in;
  output wire [W-1:0] sync_out;

  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // meta_r feeds only sync_r; nothing else may look at it
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule

// ===== core/eis_top.v
// external interrupt steering: nmi, eight dedicated lines, pci steering
`timescale 1ns/1ps
`include "eis_defs.vh"

// What this block does
// - asserted nmi gives the core a non-maskable event; the mask never blocks it
// - nmi is level detected and wins over every other interrupt source
// - lines 4..7, and lines 0..3 while steered to the core, work in dedicated mode at their own fixed level
// - lines 0..3 steer to core input or pci outputs a, b, c, d
// - an asserted pci output stays asserted, open drain, until the driver clears
// - pci outputs assert and release with no alignment to the pci clock
module eis_top #(
  parameter N_EXT = `EIS_N_EXT,
  parameter N_LOW = `EIS_N_LOW,
  parameter SRC_W = `EIS_SRC_W
) (
  clk,
  rst_b,
  nmi_n,
  ext_irq_low_group_n,
  ext_irq_high_group_n,
  core_irq_mask,
  steer_wr,
  steer_wdata,
  pci_clr,
  steer_cfg,
  core_nmi,
  core_nmi_evt,
  core_xint_n,
  core_irq_req,
  core_irq_src,
  pci_int_o,
  pci_int_oe,
  pci_pend
);
  input  wire             clk;
  input  wire             rst_b;
  input  wire             nmi_n;
  input  wire [N_LOW-1:0] ext_irq_low_group_n;
  input  wire [N_LOW-1:0] ext_irq_high_group_n;
  input  wire [N_EXT-1:0] core_irq_mask;
  input  wire             steer_wr;
  input  wire [N_LOW-1:0] steer_wdata;
  input  wire [N_LOW-1:0] pci_clr;
  output wire [N_LOW-1:0] steer_cfg;
  output wire             core_nmi;
  output wire             core_nmi_evt;
  output wire [N_EXT-1:0] core_xint_n;
  output wire             core_irq_req;
  output wire [SRC_W-1:0] core_irq_src;
  output wire [N_LOW-1:0] pci_int_o;
  output wire [N_LOW-1:0] pci_int_oe;
  output wire [N_LOW-1:0] pci_pend;

  // --------------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------------
  wire             nmi_n_s;
  wire [N_EXT-1:0] xint_n_s;

  eis_sync #(
    .W       (1),
    .RST_VAL (1'b1)
  ) u_sync_nmi (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in (nmi_n),
    .sync_out (nmi_n_s)
  );

  eis_sync #(
    .W       (N_EXT),
    .RST_VAL ({N_EXT{1'b1}})
  ) u_sync_xint (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in ({ext_irq_high_group_n, ext_irq_low_group_n}),
    .sync_out (xint_n_s)
  );

  // active-high view of synchronised requests
  wire             nmi_req = ~nmi_n_s;
  wire [N_EXT-1:0] ext_req = ~xint_n_s;

  // --------------------------------------------------------------------------
  // steering configuration
  // --------------------------------------------------------------------------
  reg  [N_LOW-1:0] steer_r;
  wire [N_LOW-1:0] steer_nxt = steer_wr ? steer_wdata : steer_r;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      steer_r <= `EIS_STEER_RST;
    end else begin
      steer_r <= steer_nxt;
    end
  end

  assign steer_cfg = steer_r;

  // --------------------------------------------------------------------------
  // nmi path
  // --------------------------------------------------------------------------
  // level detect: core_nmi follows the line for as long as it is held,
  // the event pulse marks each new assertion; no mask term is applied
  reg nmi_r;
  reg nmi_evt_r;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nmi_r     <= 1'b0;
      nmi_evt_r <= 1'b0;
    end else begin
      nmi_r     <= nmi_req;
      nmi_evt_r <= nmi_req & ~nmi_r;
    end
  end

  assign core_nmi     = nmi_r;
  assign core_nmi_evt = nmi_evt_r;

  // --------------------------------------------------------------------------
  // core delivery of external lines
  // --------------------------------------------------------------------------
  // a low line steered to pci is hidden from the core; the high group
  // always goes to the core on its own dedicated input
  wire [N_EXT-1:0] to_core;
  wire [N_EXT-1:0] core_req;

  genvar gi;
  generate
    for (gi = 0; gi < N_EXT; gi = gi + 1) begin : g_route
      if (gi < N_LOW) begin : g_low
        assign to_core[gi] = (steer_r[gi] == `EIS_STEER_CORE);
      end else begin : g_high
        assign to_core[gi] = 1'b1;
      end
      assign core_req[gi] = ext_req[gi] & to_core[gi];
    end
  endgenerate

  reg [N_EXT-1:0] core_xint_n_r;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      core_xint_n_r <= `EIS_XINT_IDLE;
    end else begin
      core_xint_n_r <= ~core_req;
    end
  end

  assign core_xint_n = core_xint_n_r;

  // --------------------------------------------------------------------------
  // source prioritisation
  // --------------------------------------------------------------------------
  // each line carries a fixed level: line i is level i + base, the higher
  // line index winning; the mask gates external lines only
  function [SRC_W-1:0] eis_pick;
    input [N_EXT-1:0] req;
    integer k;
    begin
      eis_pick = `EIS_SRC_NONE;
      for (k = 0; k < N_EXT; k = k + 1) begin
        if (req[k]) begin
          eis_pick = k[SRC_W-1:0] + `EIS_SRC_EXT_BASE;
        end
      end
    end
  endfunction

  wire [N_EXT-1:0] core_live = core_req & ~core_irq_mask;
  reg  [SRC_W-1:0] src_nxt;
  reg              req_nxt;

  always @* begin
    src_nxt = `EIS_SRC_NONE;
    req_nxt = 1'b0;
    if (nmi_req) begin
      src_nxt = `EIS_SRC_NMI;
      req_nxt = 1'b1;
    end else if (|core_live) begin
      src_nxt = eis_pick(core_live);
      req_nxt = 1'b1;
    end
  end

  reg [SRC_W-1:0] src_r;
  reg             req_r;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      src_r <= `EIS_SRC_NONE;
      req_r <= 1'b0;
    end else begin
      src_r <= src_nxt;
      req_r <= req_nxt;
    end
  end

  assign core_irq_src = src_r;
  assign core_irq_req = req_r;

  // --------------------------------------------------------------------------
  // pci interrupt outputs
  // --------------------------------------------------------------------------
  // pending latches while the device holds its line (it keeps it asserted
  // until serviced); only the driver clear drops it, and a set arriving in
  // the clear cycle wins so the request is never lost
  reg  [N_LOW-1:0] pend_r;
  wire [N_LOW-1:0] pci_set  = ext_req[N_LOW-1:0] & steer_r;
  wire [N_LOW-1:0] pend_nxt = pci_set | (pend_r & ~pci_clr);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_r <= `EIS_PEND_RST;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // open drain: drive low while pending, float otherwise; no pci clock is
  // used, so edges sit on this block's clock only
  assign pci_int_o  = {N_LOW{1'b0}};
  assign pci_int_oe = pend_r;
  assign pci_pend   = pend_r;

endmodule

// ===== dv/eis_asserts.sv
// checker for the interrupt steering stage
`timescale 1ns/1ps
module eis_asserts (
  input wire       clk,
  input wire       rst_b,
  input wire       nmi_n,
  input wire [3:0] ext_irq_low_group_n,
  input wire       steer_wr,
  input wire [3:0] steer_wdata,
  input wire [3:0] pci_clr,
  input wire [3:0] steer_cfg,
  input wire       core_nmi,
  input wire       core_nmi_evt,
  input wire [7:0] core_xint_n,
  input wire       core_irq_req,
  input wire [3:0] core_irq_src,
  input wire [3:0] pci_int_o,
  input wire [3:0] pci_int_oe,
  input wire [3:0] pci_pend
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // four samples exactly cover the sync plus register path, with no edge of slack
  sequence s_nmi_low; !nmi_n [*4]; endsequence
  sequence s_pci0; (!ext_irq_low_group_n[0] && steer_cfg[0]) [*4]; endsequence
  property p_nmi; s_nmi_low |-> core_nmi && core_irq_req && core_irq_src == 4'hf; endproperty
  property p_evt; core_nmi_evt |-> core_nmi && !$past(core_nmi); endproperty
  property p_rise; $rose(core_nmi) |-> core_nmi_evt; endproperty
  property p_lvl; nmi_n [*4] |-> !core_nmi; endproperty
  property p_od; pci_int_o == 4'h0 && pci_int_oe == pci_pend; endproperty
  property p_hold; 1'b1 |=> ($past(pci_pend) & ~$past(pci_clr) & ~pci_pend) == 4'h0; endproperty
  property p_wr; steer_wr |=> steer_cfg == $past(steer_wdata); endproperty
  property p_keep; !steer_wr |=> $stable(steer_cfg); endproperty
  property p_pci0; s_pci0 |-> core_xint_n[0] && pci_pend[0]; endproperty
  property p_core0; (!ext_irq_low_group_n[0] && !steer_cfg[0]) [*4] |-> !core_xint_n[0]; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi lost");
  a_evt: assert property (p_evt) else $error("stray nmi event");
  a_rise: assert property (p_rise) else $error("nmi event missing");
  a_lvl: assert property (p_lvl) else $error("nmi without pin");
  a_od: assert property (p_od) else $error("pci open drain");
  a_hold: assert property (p_hold) else $error("pci dropped early");
  a_wr: assert property (p_wr) else $error("steer write");
  a_keep: assert property (p_keep) else $error("steer moved");
  a_pci0: assert property (p_pci0) else $error("line 0 not on pci");
  a_core0: assert property (p_core0) else $error("line 0 not on core");
endmodule

bind eis_top eis_asserts u_chk (.clk, .rst_b, .nmi_n, .ext_irq_low_group_n, .steer_wr,
  .steer_wdata, .pci_clr, .steer_cfg, .core_nmi, .core_nmi_evt, .core_xint_n, .core_irq_req,
  .core_irq_src, .pci_int_o, .pci_int_oe, .pci_pend);

// ===== dv/eis_partner.sv
// model of the interrupting devices and the pci host driver
`timescale 1ns/1ps
module eis_partner (
  input  wire       clk,
  input  wire       nmi_req,
  input  wire [7:0] dev_req,
  input  wire [3:0] clr_req,
  output reg        nmi_n   = 1'b1,
  output reg  [7:0] xint_n  = 8'hff,
  output reg  [3:0] pci_clr = 4'h0
);
  // a device holds its line low until the bench marks it serviced
  always @(posedge clk) begin
    nmi_n <= ~nmi_req;
    xint_n <= ~dev_req;
    pci_clr <= clr_req;
  end
endmodule

// ===== dv/test_external_interrupt_steering.sv
// self-checking bench for the interrupt steering stage
`timescale 1ns/1ps
`include "eis_defs.vh"
module test_external_interrupt_steering;
  reg        clk = 1'b0, rst_b = 1'b0, nmi_req = 1'b0, steer_wr = 1'b0;
  reg  [7:0] dev_req = 8'h00, mask = 8'h00;
  reg  [3:0] clr_req = 4'h0, wdata = 4'h0;
  wire       nmi_n, core_nmi, nmi_evt, irq_req;
  wire [7:0] ext_n, xint_n;
  wire [3:0] pci_clr, steer_cfg, src, pci_o, pci_oe, pend;
  integer    errors = 0, samples_checked = 0, cycles = 0, i;
  eis_partner PM (.clk(clk), .nmi_req(nmi_req), .dev_req(dev_req), .clr_req(clr_req),
    .nmi_n(nmi_n), .xint_n(ext_n), .pci_clr(pci_clr));
  eis_top DUT (.clk(clk), .rst_b(rst_b), .nmi_n(nmi_n), .ext_irq_low_group_n(ext_n[3:0]),
    .ext_irq_high_group_n(ext_n[7:4]), .core_irq_mask(mask), .steer_wr(steer_wr),
    .steer_wdata(wdata), .pci_clr(pci_clr), .steer_cfg(steer_cfg), .core_nmi(core_nmi),
    .core_nmi_evt(nmi_evt), .core_xint_n(xint_n), .core_irq_req(irq_req),
    .core_irq_src(src), .pci_int_o(pci_o), .pci_int_oe(pci_oe), .pci_pend(pend));
  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors = errors + 1;
      conclude;
    end
  end
  task conclude;
    begin
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("BAD %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  // partner edge plus two sync edges plus output register, with slack
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task t_reset;
    begin
      chk(steer_cfg, `EIS_STEER_RST);
      chk(xint_n, `EIS_XINT_IDLE);
      chk({pci_o, pci_oe}, 8'h00);
      chk({core_nmi, nmi_evt, irq_req, src}, 8'h00);
    end
  endtask
  task t_lines;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        @(posedge clk) dev_req <= 8'h01 << i;
        mask <= 8'h00;
        tick(6);
        chk(xint_n, ~(8'h01 << i));
        chk(pend, 8'h00);
        chk(src, i + 1);
        @(posedge clk) mask <= 8'h01 << i;
        tick(2);
        chk(irq_req, 1'b0);
        chk(xint_n, ~(8'h01 << i));
      end
      @(posedge clk) dev_req <= 8'h81;
      mask <= 8'h00;
      tick(6);
      chk(src, 8'h08);
    end
  endtask
  task t_nmi;
    begin
      // lines 7 and 0 stay unmasked so nmi has to win over them
      @(posedge clk) nmi_req <= 1'b1;
      tick(4);
      chk({core_nmi, nmi_evt}, 2'b11);
      tick(2);
      chk({core_nmi, nmi_evt, irq_req, src}, {3'b101, `EIS_SRC_NMI});
      @(posedge clk) mask <= 8'hff;
      tick(2);
      chk({core_nmi, irq_req, src}, {2'b11, `EIS_SRC_NMI});
      @(posedge clk) nmi_req <= 1'b0;
      tick(6);
      chk({core_nmi, irq_req}, 2'b00);
      @(posedge clk) dev_req <= 8'h00;
    end
  endtask
  task t_steer;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        @(posedge clk) steer_wr <= 1'b1;
        wdata <= 4'h1 << i;
        @(posedge clk) steer_wr <= 1'b0;
        dev_req <= 8'h01 << i;
        tick(6);
        chk({steer_cfg, pend}, {2{4'h1 << i}});
        chk(xint_n, 8'hff);
        // a clear while the line is still low must not win
        @(posedge clk) clr_req <= 4'h1 << i;
        @(posedge clk) clr_req <= 4'h0;
        dev_req <= 8'h00;
        tick(6);
        chk(pend, 4'h1 << i);
        @(posedge clk) clr_req <= 4'h1 << i;
        @(posedge clk) clr_req <= 4'h0;
        tick(3);
        chk({pend, pci_oe}, 8'h00);
      end
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    tick(1);
    t_reset;
    t_lines;
    t_nmi;
    t_steer;
    @(posedge clk) rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    tick(1);
    t_reset;
    conclude;
  end
endmodule
